// File: src/ccdr_pkg.sv
// Geometry, timing constants and carrier types for the CCD readout model
package ccdr_pkg;

  // Array geometry
  localparam int ACT_COLS        = 1732;
  localparam int ACT_ROWS        = 1172;
  localparam int DARK_LEAD_COLS  = 20;
  localparam int DARK_TRAIL_COLS = 6;
  localparam int DARK_LEAD_ROWS  = 20;
  localparam int DARK_TRAIL_ROWS = 4;
  localparam int BUF_PIX         = 10;
  localparam int DUMMY_LEAD      = 12;
  localparam int DUMMY_TRAIL     = 2;
  localparam int FLUSH_ROWS      = 1216;
  localparam int STRAY_ROWS      = 2;
  localparam int FALSE_DUMMY     = 4;

  // Derived positions within a row and a frame
  localparam int DARK_L_END = DUMMY_LEAD + DARK_LEAD_COLS;
  localparam int INNER_END  = DARK_L_END + ACT_COLS;
  localparam int DARK_T_END = INNER_END + DARK_TRAIL_COLS;
  localparam int STAGES     = DARK_T_END + DUMMY_TRAIL;
  localparam int ROW_IN_END = DARK_LEAD_ROWS + ACT_ROWS;
  localparam int FRAME_ROWS = ROW_IN_END + DARK_TRAIL_ROWS;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int VPULSE_MIN_NS = 5000;
  localparam int INTEG_MIN_CYC = (VPULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CHG_W = 12;
  localparam int POS_W = 11;
  localparam logic [CHG_W-1:0] RESET_LEVEL = 12'hfff;

  typedef enum logic [1:0] {
    CCDR_DUMMY,
    CCDR_DARK,
    CCDR_BUFFER,
    CCDR_ACTIVE
  } ccdr_region_t;

  typedef enum logic [1:0] {
    CCDR_WAIT,
    CCDR_EXPOSE,
    CCDR_PRIME,
    CCDR_READ
  } ccdr_state_t;

  typedef struct packed {
    logic v1;
    logic v2;
    logic h1;
    logic h2;
    logic rg;
  } ccdr_phase_t;

  typedef struct packed {
    logic             strobe;
    logic [CHG_W-1:0] video;
    ccdr_region_t     region;
    logic [POS_W-1:0] col;
    logic [POS_W-1:0] row;
    logic             unclean;
  } ccdr_video_t;

endpackage

// File: src/ccdr_sensor.sv
// Full-frame CCD sensor model: phase decode, row transfer, shift-out and video
`timescale 1ns/1ns
module ccdr_sensor #(
  parameter int INTEG_MIN = ccdr_pkg::INTEG_MIN_CYC
) (
  input  wire logic                            core_clk,
  input  wire logic                            srst,
  input  wire ccdr_pkg::ccdr_phase_t           phase_pins,
  input  wire logic [ccdr_pkg::CHG_W-1:0]      scene_charge,
  output ccdr_pkg::ccdr_video_t                video_out,
  output logic                                 integrating,
  output logic                                 load_fault,
  output logic                                 frame_done
);

  generate
    if (ccdr_pkg::STAGES >= (1 << ccdr_pkg::POS_W) || ccdr_pkg::FLUSH_ROWS >= (1 << ccdr_pkg::POS_W)) begin : g_chk_pos
      $error("Position counters too narrow for the array");
    end
    if (INTEG_MIN < 1 || INTEG_MIN >= (1 << 16)) begin : g_chk_integ
      $error("INTEG_MIN out of range");
    end
  endgenerate

  // Three-stage pin synchroniser; a change counts once stages two and three agree
  ccdr_pkg::ccdr_phase_t s1_r, s2_r, s3_r, filt_r, prev_r;
  ccdr_pkg::ccdr_phase_t filt_nxt;

  always_comb begin
    filt_nxt = filt_r;
    if (s2_r == s3_r) begin
      filt_nxt = s3_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
      prev_r <= '0;
    end else begin
      s1_r   <= phase_pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  logic v2_rise, h2_fall, rg_rise, vert_low;
  assign v2_rise  = filt_r.v2 & ~prev_r.v2;
  assign h2_fall  = ~filt_r.h2 & prev_r.h2;
  assign rg_rise  = filt_r.rg & ~prev_r.rg;
  assign vert_low = ~filt_r.v1 & ~filt_r.v2;

  // Region of a register stage within a given row
  function automatic ccdr_pkg::ccdr_region_t region_of(input logic [ccdr_pkg::POS_W-1:0] c,
                                                       input logic [ccdr_pkg::POS_W-1:0] r);
    int cc;
    int rr;
    cc = int'(c) - ccdr_pkg::DARK_L_END;
    rr = int'(r) - ccdr_pkg::DARK_LEAD_ROWS;
    if (int'(c) < ccdr_pkg::DUMMY_LEAD || int'(c) >= ccdr_pkg::DARK_T_END) begin
      region_of = ccdr_pkg::CCDR_DUMMY;
    end else if (cc < 0 || int'(c) >= ccdr_pkg::INNER_END) begin
      region_of = ccdr_pkg::CCDR_DARK;
    end else if (rr < 0 || int'(r) >= ccdr_pkg::ROW_IN_END) begin
      region_of = ccdr_pkg::CCDR_DARK;
    end else if (cc < ccdr_pkg::BUF_PIX || cc >= ccdr_pkg::ACT_COLS - ccdr_pkg::BUF_PIX ||
                 rr < ccdr_pkg::BUF_PIX || rr >= ccdr_pkg::ACT_ROWS - ccdr_pkg::BUF_PIX) begin
      region_of = ccdr_pkg::CCDR_BUFFER;
    end else begin
      region_of = ccdr_pkg::CCDR_ACTIVE;
    end
  endfunction

  // Stray pickup: leading rows, dark stages beside the light area or the chip edge, early dummies
  function automatic logic unclean_of(input logic [ccdr_pkg::POS_W-1:0] c,
                                      input logic [ccdr_pkg::POS_W-1:0] r);
    int ci;
    ci = int'(c);
    unclean_of = (int'(r) < ccdr_pkg::STRAY_ROWS) ||
                 (ci == ccdr_pkg::DUMMY_LEAD) || (ci == ccdr_pkg::DARK_L_END - 1) ||
                 (ci == ccdr_pkg::INNER_END) || (ci == ccdr_pkg::DARK_T_END - 1) ||
                 (int'(r) == ccdr_pkg::DARK_LEAD_ROWS - 1) || (int'(r) == ccdr_pkg::ROW_IN_END) ||
                 (ci < ccdr_pkg::FALSE_DUMMY);
  endfunction

  // Frame sequencing and charge transport
  ccdr_pkg::ccdr_state_t state_r, state_nxt;
  logic [15:0]                  integ_cnt_r, integ_cnt_nxt;
  logic [ccdr_pkg::POS_W-1:0]   row_r, row_nxt;
  logic [ccdr_pkg::POS_W-1:0]   col_r, col_nxt;
  logic                         row_held_r, row_held_nxt;
  logic [ccdr_pkg::CHG_W-1:0]   sense_r, sense_nxt;
  ccdr_pkg::ccdr_video_t        vid_r, vid_nxt;
  logic                         integ_r, integ_nxt;
  logic                         fault_r, fault_nxt;
  logic                         done_r, done_nxt;
  ccdr_pkg::ccdr_region_t       reg_now;

  always_comb begin
    state_nxt     = state_r;
    integ_cnt_nxt = integ_cnt_r;
    row_nxt       = row_r;
    col_nxt       = col_r;
    row_held_nxt  = row_held_r;
    sense_nxt     = sense_r;
    integ_nxt     = 1'b0;
    fault_nxt     = fault_r;
    done_nxt      = 1'b0;
    vid_nxt       = vid_r;
    vid_nxt.strobe = 1'b0;
    reg_now       = region_of(col_r, row_r);

    // Verticals held low long enough count as exposure; any vertical motion ends it
    if (vert_low) begin
      if (integ_cnt_r != 16'hffff) begin
        integ_cnt_nxt = integ_cnt_r + 16'h0001;
      end
    end else begin
      integ_cnt_nxt = 16'h0000;
    end

    case (state_r)
      // Flush rows or idle clocking: row transfers dump charge, nothing is tagged as a frame
      ccdr_pkg::CCDR_WAIT: begin
        if (vert_low && int'(integ_cnt_r) >= INTEG_MIN - 1) begin
          state_nxt = ccdr_pkg::CCDR_EXPOSE;
          fault_nxt = 1'b0;
        end
      end
      ccdr_pkg::CCDR_EXPOSE: begin
        integ_nxt = 1'b1;
        if (v2_rise) begin
          state_nxt = ccdr_pkg::CCDR_READ;
          row_nxt   = '0;
          row_held_nxt = 1'b0;
        end else if (!vert_low) begin
          state_nxt = ccdr_pkg::CCDR_PRIME;
        end
      end
      // Vertical one moved first; the priming vertical two pulse is still owed
      ccdr_pkg::CCDR_PRIME: begin
        if (v2_rise) begin
          state_nxt    = ccdr_pkg::CCDR_READ;
          row_nxt      = '0;
          row_held_nxt = 1'b0;
        end
      end
      ccdr_pkg::CCDR_READ: begin
        if (v2_rise) begin
          if (!filt_r.h1) begin
            fault_nxt = 1'b1;
          end
          if (row_held_r) begin
            row_nxt = row_r + 11'h001;
          end
          row_held_nxt = 1'b1;
          col_nxt      = '0;
          if (row_held_r && int'(row_r) == ccdr_pkg::FRAME_ROWS - 1) begin
            state_nxt    = ccdr_pkg::CCDR_WAIT;
            row_held_nxt = 1'b0;
            done_nxt     = 1'b1;
          end
        end
      end
      default: state_nxt = ccdr_pkg::CCDR_WAIT;
    endcase

    // One stage reaches the sense node on each horizontal two fall while a row is held, unless vertical two rises in that cycle
    if (h2_fall && row_held_r && !v2_rise) begin
      if (reg_now == ccdr_pkg::CCDR_ACTIVE || reg_now == ccdr_pkg::CCDR_BUFFER) begin
        sense_nxt = scene_charge;
      end else begin
        sense_nxt = '0;
      end
      vid_nxt.strobe  = 1'b1;
      vid_nxt.region  = reg_now;
      vid_nxt.col     = col_r;
      vid_nxt.row     = row_r;
      vid_nxt.unclean = unclean_of(col_r, row_r);
      if (int'(col_r) < ccdr_pkg::STAGES - 1) begin
        col_nxt = col_r + 11'h001;
      end
    end else if (rg_rise) begin
      sense_nxt = '0;
    end
    // Output falls as charge rises
    vid_nxt.video = ccdr_pkg::RESET_LEVEL - sense_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r     <= ccdr_pkg::CCDR_WAIT;
      integ_cnt_r <= '0;
      row_r       <= '0;
      col_r       <= '0;
      row_held_r  <= 1'b0;
      sense_r     <= '0;
      vid_r       <= '{strobe: 1'b0, video: ccdr_pkg::RESET_LEVEL, region: ccdr_pkg::CCDR_DUMMY,
                       col: '0, row: '0, unclean: 1'b0};
      integ_r     <= 1'b0;
      fault_r     <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      integ_cnt_r <= integ_cnt_nxt;
      row_r       <= row_nxt;
      col_r       <= col_nxt;
      row_held_r  <= row_held_nxt;
      sense_r     <= sense_nxt;
      vid_r       <= vid_nxt;
      integ_r     <= integ_nxt;
      fault_r     <= fault_nxt;
      done_r      <= done_nxt;
    end
  end

  assign video_out   = vid_r;
  assign integrating = integ_r;
  assign load_fault  = fault_r;
  assign frame_done  = done_r;

endmodule

// File: tb/ccdr_sensor_properties.sv
// Port-level checks for the CCD sensor model
`timescale 1ns/1ns
module ccdr_sensor_chk #(
  parameter int INTEG_MIN = 4
) (
  input wire logic                       core_clk,
  input wire logic                       srst,
  input wire ccdr_pkg::ccdr_phase_t      phase_pins,
  input wire logic [ccdr_pkg::CHG_W-1:0] scene_charge,
  input wire ccdr_pkg::ccdr_video_t      video_out,
  input wire logic                       integrating,
  input wire logic                       load_fault,
  input wire logic                       frame_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire        st = video_out.strobe;
  wire [10:0] c  = video_out.col;
  wire [10:0] r  = video_out.row;
  wire        ac = video_out.region == ccdr_pkg::CCDR_ACTIVE;
  property p_pulse; st |=> !st; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_done; frame_done |=> !frame_done; endproperty
  a_done: assert property (p_done) else $error("done too long");
  property p_dummy; st && c < 12 |-> video_out.region == ccdr_pkg::CCDR_DUMMY && video_out.video == 12'hfff; endproperty
  a_dummy: assert property (p_dummy) else $error("bad dummy");
  property p_dark; st && c >= 12 && c < 32 |-> video_out.region == ccdr_pkg::CCDR_DARK; endproperty
  a_dark: assert property (p_dark) else $error("bad dark col");
  property p_rows; st && r < 20 |-> !ac && video_out.region != ccdr_pkg::CCDR_BUFFER; endproperty
  a_rows: assert property (p_rows) else $error("bad dark row");
  property p_act; st && ac |-> c >= 42 && c < 1754 && r >= 30 && r < 1182; endproperty
  a_act: assert property (p_act) else $error("bad active");
  property p_inv; st && ac |-> video_out.video == 12'hfff - $past(scene_charge); endproperty
  a_inv: assert property (p_inv) else $error("bad video");
  property p_uncl; st && (c < 4 || r < 2) |-> video_out.unclean; endproperty
  a_uncl: assert property (p_uncl) else $error("bad unclean");
  property p_exp; integrating |-> !st; endproperty
  a_exp: assert property (p_exp) else $error("strobe in exposure");
endmodule
bind ccdr_sensor ccdr_sensor_chk #(.INTEG_MIN(INTEG_MIN)) u_chk (.core_clk(core_clk), .srst(srst),
  .phase_pins(phase_pins), .scene_charge(scene_charge), .video_out(video_out),
  .integrating(integrating), .load_fault(load_fault), .frame_done(frame_done));

// File: tb/ccdr_timing_gen.sv
// Camera timing generator model driving the sensor phases
`timescale 1ns/1ns
module ccdr_timing_gen (
  input wire logic              core_clk,
  output ccdr_pkg::ccdr_phase_t phase_pins
);
  // Idle: horizontal one high, all else low
  initial phase_pins = 5'b00100;
  task automatic hold(input logic [4:0] p, input int n);
    @(negedge core_clk);
    phase_pins = p;
    repeat (n - 1) @(negedge core_clk);
  endtask
  // Reset gate keeps running through exposure, verticals stay low
  task automatic expose(input int n);
    repeat (n / 6) begin
      hold(5'b00101, 3);
      hold(5'b00100, 3);
    end
  endtask
  // Same pulse serves the extra frame-start pulse and row moves
  task automatic vpulse(input logic h1);
    hold({2'b10, h1, 2'b00}, 3);
    hold({2'b01, h1, 2'b00}, 3);
    hold(5'b00100, 3);
  endtask
  // Reset gate only after the sample window, never with the h2 fall
  task automatic pixel();
    hold(5'b00010, 3);
    hold(5'b00100, 3);
    hold(5'b00101, 3);
    hold(5'b00100, 3);
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the CCD sensor model
`timescale 1ns/1ns
module testbench;
  localparam int IMIN = 16;
  // col, region, video, unclean at row 30 with charge 123
  // Other stages carry their own column as charge, so the inversion property sees many values
  localparam logic [25:0] CASES [11] = '{
    {11'h000, 2'h0, 12'hfff, 1'h1}, {11'h004, 2'h0, 12'hfff, 1'h0}, {11'h00c, 2'h1, 12'hfff, 1'h1},
    {11'h00d, 2'h1, 12'hfff, 1'h0}, {11'h020, 2'h2, 12'hedc, 1'h0}, {11'h029, 2'h2, 12'hedc, 1'h0},
    {11'h02a, 2'h3, 12'hedc, 1'h0}, {11'h6d9, 2'h3, 12'hedc, 1'h0}, {11'h6da, 2'h2, 12'hedc, 1'h0},
    {11'h6e4, 2'h1, 12'hfff, 1'h1}, {11'h6ea, 2'h0, 12'hfff, 1'h0}};
  logic                  core_clk;
  logic                  srst;
  logic [11:0]           scene_charge;
  ccdr_pkg::ccdr_phase_t phase_pins;
  ccdr_pkg::ccdr_video_t video_out;
  ccdr_pkg::ccdr_video_t got;
  logic                  integrating;
  logic                  load_fault;
  logic                  frame_done;
  int                    errors = 0;
  int                    total_checks = 0;
  int                    nstb = 0;
  int                    ndone = 0;
  int                    k = 0;
  ccdr_sensor #(.INTEG_MIN(IMIN)) DUT (.core_clk(core_clk), .srst(srst), .phase_pins(phase_pins),
    .scene_charge(scene_charge), .video_out(video_out), .integrating(integrating),
    .load_fault(load_fault), .frame_done(frame_done));
  ccdr_timing_gen gen (.core_clk(core_clk), .phase_pins(phase_pins));
  task automatic close_out();
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_v(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_v({11'h0, g}, {11'h0, e});
  endtask
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (video_out.strobe === 1'b1) begin
      got <= video_out;
      nstb <= nstb + 1;
    end
    if (frame_done === 1'b1)
      ndone <= ndone + 1;
  end
  initial begin
    srst = 1;
    scene_charge = 12'h123;
    repeat (2) @(negedge core_clk);
    srst = 0;
    gen.expose(IMIN + 8);
    chk_b(integrating, 1'b1);
    gen.vpulse(1'b1);
    gen.vpulse(1'b1);
    repeat (3) gen.pixel();
    chk_b(got.unclean, 1'b1);
    chk_v({1'h0, got.row}, 12'h000);
    repeat (30) gen.vpulse(1'b1);
    for (int p = 0; p < ccdr_pkg::STAGES; p++) begin
      scene_charge = (k < 11 && p == int'(CASES[k][25:15])) ? 12'h123 : 12'(p);
      gen.pixel();
      if (nstb != p + 4) begin
        errors++;
        $display("FAIL %0t no strobe", $time);
        close_out();
      end
      if (k < 11 && p == int'(CASES[k][25:15])) begin
        chk_v({1'h0, got.col}, {1'h0, CASES[k][25:15]});
        chk_v({1'h0, got.row}, 12'h01e);
        chk_v({10'h0, got.region}, {10'h0, CASES[k][14:13]});
        chk_v(got.video, CASES[k][12:1]);
        chk_b(got.unclean, CASES[k][0]);
        chk_v(video_out.video, 12'hfff);
        k++;
      end
    end
    repeat (1165) gen.vpulse(1'b1);
    chk_b(ndone == 0, 1'b1);
    gen.vpulse(1'b1);
    for (int i = 0; i < 20 && ndone == 0; i++) @(negedge core_clk);
    chk_b(ndone == 1, 1'b1);
    gen.expose(IMIN + 8);
    gen.vpulse(1'b1);
    gen.vpulse(1'b0);
    chk_b(load_fault, 1'b1);
    srst = 1;
    repeat (2) @(negedge core_clk);
    srst = 0;
    chk_b(load_fault, 1'b0);
    chk_b(integrating, 1'b0);
    chk_v(video_out.video, 12'hfff);
    // Extra pulse on vertical two alone, without vertical one moving first
    gen.expose(IMIN + 8);
    gen.hold(5'b01100, 3);
    gen.hold(5'b00100, 3);
    gen.vpulse(1'b1);
    gen.pixel();
    chk_v({1'h0, got.row}, 12'h000);
    chk_v({1'h0, got.col}, 12'h000);
    chk_b(load_fault, 1'b0);
    close_out();
  end
endmodule
